// ### core/dps_device_end.sv
/*
 * Debug end of the core: test port logic on the link clock, halt and
 * pipeline save logic on the core clock, with a toggle handshake between.
 * Assumes the core raises haltReq to stop, instrDone after an injected
 * instruction, and writes trace entries only while running.
 */
`default_nettype none
module dps_device_end (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	dps_if.device link,
	input wire logic haltReq,
	input wire logic instrDone,
	input wire logic [dps_pkg::WORD_W-1:0] fetchAddr,
	input wire logic [dps_pkg::WORD_W-1:0] decodeAddr,
	input wire logic [dps_pkg::WORD_W-1:0] execAddr,
	input wire logic [dps_pkg::WORD_W-1:0] programDataBus,
	input wire logic [dps_pkg::WORD_W-1:0] instrLatchIn,
	input wire logic traceWe,
	input wire logic [dps_pkg::WORD_W-1:0] traceAddr,
	input wire logic traceInvalid,
	input wire logic xbufWe,
	input wire logic [dps_pkg::WORD_W-1:0] xbufData,
	output logic halted,
	output logic execStart,
	output logic [dps_pkg::WORD_W-1:0] execWord,
	output logic latchWrite,
	output logic [dps_pkg::WORD_W-1:0] instrLatchWord,
	output logic resume,
	output logic [dps_pkg::WORD_W-1:0] programAddrBus
);
	import dps_pkg::*;

	typedef enum logic [1:0] {PH_CMD, PH_DATA, PH_READ} dps_phase_t;

	function automatic logic [TRACE_W-1:0] drShift(input logic [TRACE_W-1:0] sr, input logic b, input int top);
		logic [TRACE_W-1:0] r;
		r = sr >> 1;
		r[top] = b;
		return r;
	endfunction

	// ---------------- link clock domain ----------------
	logic [1:0] rstSync, ceSync, haltSync;
	logic tckRst, tckCe, enabled, tdoR, tckRstReq;
	dps_tap_t tapSt;
	logic [IR_W-1:0] ir, next_ir, irSr, next_irSr;
	logic [TRACE_W-1:0] drSr, next_drSr;
	dps_phase_t phase, next_phase;
	logic [CMD_W-1:0] pendCmd, next_pendCmd, reqCmd, next_reqCmd;
	logic [WORD_W-1:0] reqData, next_reqData;
	logic reqTog, next_reqTog, next_tdoR;
	int top;
	// word answered to a read, held stable by the clk side between requests
	logic [TRACE_W-1:0] rdWord;

	always_ff @(posedge link.tck) begin
		rstSync <= {rstSync[0], tckRstReq};
		ceSync <= {ceSync[0], ce};
		haltSync <= {haltSync[0], halted};
	end
	assign tckRst = rstSync[1];
	assign tckCe = ceSync[1];
	assign enabled = (ir == IR_ENABLE);

	dps_tap dps_tap_i (.tck(link.tck), .rst(tckRst), .en(tckCe), .tms(link.tms), .state(tapSt));

	always_comb begin
		next_ir = ir;
		next_irSr = irSr;
		next_drSr = drSr;
		next_phase = phase;
		next_pendCmd = pendCmd;
		next_reqCmd = reqCmd;
		next_reqData = reqData;
		next_reqTog = reqTog;
		if (!enabled) top = TOP_BYPASS;
		else if (phase == PH_CMD) top = TOP_CMD;
		else if (phase == PH_DATA) top = TOP_DATA;
		else top = TOP_READ;
		unique case (tapSt)
			TAP_TLR: begin
				next_ir = IR_BYPASS;
				next_phase = PH_CMD;
			end
			TAP_CAPIR: next_irSr = {2'h0, haltSync[1] ? STATUS_HALTED : STATUS_RUN};
			TAP_SHIR: next_irSr = {link.tdi, irSr[IR_W-1:1]};
			TAP_UPDIR: begin
				next_ir = irSr;
				next_phase = PH_CMD;
			end
			TAP_CAPDR: next_drSr = (enabled && phase == PH_READ) ? rdWord : '0;
			TAP_SHDR: next_drSr = drShift(drSr, link.tdi, top);
			TAP_UPDDR: begin
				if (enabled) begin
					unique case (phase)
						PH_CMD: begin
							if (!drSr[CMD_READ_BIT] && dps_cmd_sel(drSr[CMD_W-1:0]) == SEL_BUSWORD) begin
								next_phase = PH_DATA;
								next_pendCmd = drSr[CMD_W-1:0];
							end else begin
								next_reqTog = ~reqTog;
								next_reqCmd = drSr[CMD_W-1:0];
								next_reqData = '0;
								next_phase = drSr[CMD_READ_BIT] ? PH_READ : PH_CMD;
							end
						end
						PH_DATA: begin
							next_reqTog = ~reqTog;
							next_reqCmd = pendCmd;
							next_reqData = drSr[WORD_W-1:0];
							next_phase = PH_CMD;
						end
						PH_READ: next_phase = PH_CMD;
					endcase
				end
			end
			TAP_RTI, TAP_SELDR, TAP_EX1DR, TAP_PAUSEDR, TAP_EX2DR, TAP_SELIR, TAP_EX1IR, TAP_PAUSEIR,
			TAP_EX2IR: ;
		endcase
		next_tdoR = (tapSt == TAP_CAPIR || tapSt == TAP_SHIR) ? next_irSr[0] : next_drSr[0];
	end

	always_ff @(posedge link.tck) begin
		if (tckRst) begin
			ir <= IR_BYPASS;
			irSr <= '0;
			drSr <= '0;
			phase <= PH_CMD;
			pendCmd <= '0;
			reqCmd <= '0;
			reqData <= '0;
			reqTog <= 1'b0;
			tdoR <= 1'b0;
		end else if (tckCe) begin
			ir <= next_ir;
			irSr <= next_irSr;
			drSr <= next_drSr;
			phase <= next_phase;
			pendCmd <= next_pendCmd;
			reqCmd <= next_reqCmd;
			reqData <= next_reqData;
			reqTog <= next_reqTog;
			tdoR <= next_tdoR;
		end
	end
	assign link.tdo = tdoR;

	// ---------------- core clock domain ----------------
	logic [1:0] reqSync;
	logic reqSeen, newReq, inDebug, next_inDebug, next_halted, haltAckPinN, next_haltAckPinN;
	logic [WORD_W-1:0] savedBusWord, savedLatchWord, fetchAddrReg, decodeAddrReg, executeAddrReg;
	logic [WORD_W-1:0] exchangeBuffer, lastWord, next_savedBusWord, next_savedLatchWord;
	logic [WORD_W-1:0] next_fetchAddrReg, next_decodeAddrReg, next_executeAddrReg;
	logic [WORD_W-1:0] next_exchangeBuffer, next_lastWord, next_execWord, next_instrLatchWord;
	logic [WORD_W-1:0] next_programAddrBus;
	logic [TRACE_W-1:0] traceBuf [TRACE_DEPTH];
	logic [TRACE_W-1:0] next_traceBuf [TRACE_DEPTH];
	logic [TRACE_W-1:0] next_rdWord;
	logic [PTR_W-1:0] tracePtr, next_tracePtr;
	logic [7:0] ackCnt, next_ackCnt;
	logic next_execStart, next_latchWrite, next_resume;
	logic isRun, isResume;
	// tck is stopped while srst is high, so the link-side reset request is stretched past it
	logic [3:0] tckRstCnt, next_tckRstCnt;
	logic next_tckRstReq;
	dps_sel_t sel;

	assign newReq = reqSync[1] ^ reqSeen;
	assign sel = dps_cmd_sel(reqCmd);
	assign isRun = reqCmd[CMD_RUN_BIT];
	assign isResume = reqCmd[CMD_RESUME_BIT];

	always_comb begin
		next_inDebug = inDebug;
		next_halted = halted;
		next_savedBusWord = savedBusWord;
		next_savedLatchWord = savedLatchWord;
		next_fetchAddrReg = fetchAddrReg;
		next_decodeAddrReg = decodeAddrReg;
		next_executeAddrReg = executeAddrReg;
		next_exchangeBuffer = xbufWe ? xbufData : exchangeBuffer;
		next_lastWord = lastWord;
		next_traceBuf = traceBuf;
		next_tracePtr = tracePtr;
		next_rdWord = rdWord;
		next_execWord = execWord;
		next_instrLatchWord = instrLatchWord;
		next_programAddrBus = programAddrBus;
		next_execStart = 1'b0;
		next_latchWrite = 1'b0;
		next_resume = 1'b0;
		next_ackCnt = (ackCnt != 8'h00) ? ackCnt - 8'h01 : ackCnt;
		next_tckRstCnt = (tckRstCnt != 4'h0) ? tckRstCnt - 4'h1 : tckRstCnt;
		next_tckRstReq = (next_tckRstCnt != 4'h0);
		if (!inDebug && haltReq) begin
			next_inDebug = 1'b1;
			next_halted = 1'b1;
			next_savedBusWord = programDataBus;
			next_savedLatchWord = instrLatchIn;
			next_fetchAddrReg = fetchAddr;
			next_decodeAddrReg = decodeAddr;
			next_executeAddrReg = execAddr;
			next_ackCnt = 8'(ACK_PULSE_CYCLES);
		end else if (inDebug && !halted && instrDone) begin
			next_halted = 1'b1;
			next_ackCnt = 8'(ACK_PULSE_CYCLES);
		end
		if (!inDebug && traceWe) begin
			next_traceBuf[tracePtr] = {traceAddr, traceInvalid};
			next_tracePtr = (tracePtr == PTR_LAST) ? PTR_RESET : tracePtr + 4'h1;
		end
		if (newReq && halted) begin
			if (reqCmd[CMD_READ_BIT]) begin
				unique case (sel)
					SEL_BUSWORD: next_rdWord = {1'b0, savedBusWord};
					SEL_LATCH: next_rdWord = {1'b0, savedLatchWord};
					SEL_FETCH: next_rdWord = {1'b0, fetchAddrReg};
					SEL_DECODE: next_rdWord = {1'b0, decodeAddrReg};
					SEL_EXEC: next_rdWord = {1'b0, executeAddrReg};
					SEL_XBUF: next_rdWord = {1'b0, exchangeBuffer};
					SEL_TRACE: begin
						next_rdWord = traceBuf[tracePtr];
						next_tracePtr = (tracePtr == PTR_LAST) ? PTR_RESET : tracePtr + 4'h1;
					end
					default: next_rdWord = '0;
				endcase
			end else if (sel == SEL_BUSWORD) begin
				next_savedBusWord = reqData;
				if (isRun && isResume) begin
					next_resume = 1'b1;
					next_programAddrBus = fetchAddrReg;
					next_inDebug = 1'b0;
					next_halted = 1'b0;
				end else if (isRun) begin
					next_execStart = 1'b1;
					next_execWord = reqData;
					next_lastWord = reqData;
					next_halted = 1'b0;
				end else begin
					next_latchWrite = 1'b1;
					next_instrLatchWord = reqData;
				end
			end else if (sel == SEL_NONE && isRun && !isResume) begin
				next_execStart = 1'b1;
				next_execWord = lastWord;
				next_halted = 1'b0;
			end
		end
		next_haltAckPinN = (next_ackCnt == 8'h00);
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			reqSync <= 2'h0;
			reqSeen <= 1'b0;
			inDebug <= 1'b0;
			halted <= 1'b0;
			savedBusWord <= '0;
			savedLatchWord <= '0;
			fetchAddrReg <= '0;
			decodeAddrReg <= '0;
			executeAddrReg <= '0;
			exchangeBuffer <= '0;
			lastWord <= '0;
			traceBuf <= '{default: '0};
			tracePtr <= PTR_RESET;
			rdWord <= '0;
			execWord <= '0;
			instrLatchWord <= '0;
			programAddrBus <= '0;
			execStart <= 1'b0;
			latchWrite <= 1'b0;
			resume <= 1'b0;
			ackCnt <= 8'h00;
			haltAckPinN <= 1'b1;
			tckRstCnt <= 4'(TCK_RST_HOLD_CYCLES);
			tckRstReq <= 1'b1;
		end else if (ce) begin
			reqSync <= {reqSync[0], reqTog};
			reqSeen <= reqSync[1];
			inDebug <= next_inDebug;
			halted <= next_halted;
			savedBusWord <= next_savedBusWord;
			savedLatchWord <= next_savedLatchWord;
			fetchAddrReg <= next_fetchAddrReg;
			decodeAddrReg <= next_decodeAddrReg;
			executeAddrReg <= next_executeAddrReg;
			exchangeBuffer <= next_exchangeBuffer;
			lastWord <= next_lastWord;
			traceBuf <= next_traceBuf;
			tracePtr <= next_tracePtr;
			rdWord <= next_rdWord;
			execWord <= next_execWord;
			instrLatchWord <= next_instrLatchWord;
			programAddrBus <= next_programAddrBus;
			execStart <= next_execStart;
			latchWrite <= next_latchWrite;
			resume <= next_resume;
			ackCnt <= next_ackCnt;
			haltAckPinN <= next_haltAckPinN;
			tckRstCnt <= next_tckRstCnt;
			tckRstReq <= next_tckRstReq;
		end
	end
	assign link.haltAckN = haltAckPinN;
endmodule // dps_device_end
`default_nettype wire

// ### core/dps_host_end.sv
/*
 * Command controller end: divides clk down to the test clock and runs one
 * IR or DR scan per request from Run-Test/Idle back to Run-Test/Idle.
 * Assumes the user sequences commands and waits for haltAckSeen or polls.
 */
`default_nettype none
module dps_host_end (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	dps_if.host link,
	input wire logic scanStart,
	input wire logic scanIr,
	input wire logic [dps_pkg::LEN_W-1:0] scanLen,
	input wire logic [dps_pkg::SCAN_W-1:0] scanData,
	output logic scanBusy,
	output logic scanDone,
	output logic [dps_pkg::SCAN_W-1:0] scanResult,
	output logic haltAckSeen
);
	import dps_pkg::*;

	typedef enum logic [2:0] {H_TLR, H_IDLE, H_SELDR, H_SELIR, H_CAP, H_SHIFT, H_EXIT, H_UPD} dps_hst_t;

	dps_hst_t hst, next_hst;
	logic [1:0] divCnt, next_divCnt, tdoSync, ackSync;
	logic [2:0] rstCnt, next_rstCnt;
	logic [LEN_W-1:0] len, next_len, bitsLeft, next_bitsLeft;
	logic [SCAN_W-1:0] sh, next_sh, res, next_res, next_scanResult;
	logic tckR, next_tckR, tmsR, next_tmsR, tdiR, next_tdiR, isIr, next_isIr;
	logic ackPrev, next_scanBusy, next_scanDone, next_haltAckSeen, edgeNow, rise, fall;

	assign edgeNow = (divCnt == 2'(TCK_HALF_CYCLES - 1));
	assign rise = edgeNow && !tckR;
	assign fall = edgeNow && tckR;

	always_comb begin
		next_hst = hst;
		next_rstCnt = rstCnt;
		next_len = len;
		next_bitsLeft = bitsLeft;
		next_sh = sh;
		next_res = res;
		next_scanResult = scanResult;
		next_tmsR = tmsR;
		next_tdiR = tdiR;
		next_isIr = isIr;
		next_scanBusy = scanBusy;
		next_scanDone = 1'b0;
		next_divCnt = edgeNow ? 2'h0 : divCnt + 2'h1;
		next_tckR = edgeNow ? ~tckR : tckR;
		next_haltAckSeen = ackPrev && !ackSync[1];
		if (scanStart && !scanBusy) begin
			next_scanBusy = 1'b1;
			next_isIr = scanIr;
			next_len = scanLen;
			next_bitsLeft = scanLen;
			next_sh = scanData;
		end
		if (fall) begin
			unique case (hst)
				H_TLR: next_tmsR = (rstCnt < 3'(RESET_TMS_CYCLES));
				H_IDLE: next_tmsR = scanBusy;
				H_SELDR: next_tmsR = isIr;
				H_SELIR, H_CAP, H_UPD: next_tmsR = 1'b0;
				H_SHIFT: begin
					next_tmsR = (bitsLeft == 6'h01);
					next_tdiR = sh[0];
				end
				H_EXIT: next_tmsR = 1'b1;
			endcase
		end
		if (rise) begin
			unique case (hst)
				H_TLR: begin
					if (!tmsR) next_hst = H_IDLE;
					else if (rstCnt != 3'(RESET_TMS_CYCLES)) next_rstCnt = rstCnt + 3'h1;
				end
				H_IDLE: if (tmsR) next_hst = H_SELDR;
				H_SELDR: next_hst = tmsR ? H_SELIR : H_CAP;
				H_SELIR: next_hst = H_CAP;
				H_CAP: next_hst = H_SHIFT;
				H_SHIFT: begin
					next_res = {tdoSync[1], res[SCAN_W-1:1]};
					next_sh = sh >> 1;
					next_bitsLeft = bitsLeft - 6'h01;
					if (tmsR) next_hst = H_EXIT;
				end
				H_EXIT: next_hst = H_UPD;
				H_UPD: begin
					next_hst = H_IDLE;
					next_scanBusy = 1'b0;
					next_scanDone = 1'b1;
					next_scanResult = res >> (7'd32 - {1'b0, len});
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			hst <= H_TLR;
			rstCnt <= 3'h0;
			divCnt <= 2'h0;
			tckR <= 1'b0;
			tmsR <= 1'b1;
			tdiR <= 1'b0;
			isIr <= 1'b0;
			len <= '0;
			bitsLeft <= '0;
			sh <= '0;
			res <= '0;
			scanBusy <= 1'b0;
			scanDone <= 1'b0;
			scanResult <= '0;
			haltAckSeen <= 1'b0;
			tdoSync <= 2'h0;
			ackSync <= 2'h3;
			ackPrev <= 1'b1;
		end else if (ce) begin
			hst <= next_hst;
			rstCnt <= next_rstCnt;
			divCnt <= next_divCnt;
			tckR <= next_tckR;
			tmsR <= next_tmsR;
			tdiR <= next_tdiR;
			isIr <= next_isIr;
			len <= next_len;
			bitsLeft <= next_bitsLeft;
			sh <= next_sh;
			res <= next_res;
			scanBusy <= next_scanBusy;
			scanDone <= next_scanDone;
			scanResult <= next_scanResult;
			haltAckSeen <= next_haltAckSeen;
			tdoSync <= {tdoSync[0], link.tdo};
			ackSync <= {ackSync[0], link.haltAckN};
			ackPrev <= ackSync[1];
		end
	end
	assign link.tck = tckR;
	assign link.tms = tmsR;
	assign link.tdi = tdiR;
endmodule // dps_host_end
`default_nettype wire

// ### core/dps_if.sv
/*
 * Serial test link between the debug port and its command controller.
 * Assumes the host end drives the test clock; all pins are point to point.
 */
`default_nettype none
interface dps_if;
	logic tck;
	logic tms;
	logic tdi;
	logic tdo;
	logic haltAckN;
	modport device(input tck, input tms, input tdi, output tdo, output haltAckN);
	modport host(output tck, output tms, output tdi, input tdo, input haltAckN);
endinterface
`default_nettype wire

// ### core/dps_pkg.sv
/*
 * Shared constants, types and decode helpers of the debug port sequencer.
 * Assumes both ends and the bench compile this package first.
 */
`default_nettype none
package dps_pkg;
	localparam int CMD_W = 8;
	localparam int WORD_W = 24;
	localparam int TRACE_W = 25;
	localparam int TRACE_DEPTH = 12;
	localparam int PTR_W = 4;
	localparam int IR_W = 4;
	localparam int SCAN_W = 32;
	localparam int LEN_W = 6;
	// command word layout
	localparam int CMD_READ_BIT = 7;
	localparam int CMD_RUN_BIT = 6;
	localparam int CMD_RESUME_BIT = 5;
	localparam int CMD_SEL_LSB = 0;
	localparam int CMD_SEL_W = 4;
	// shift register top positions per scan kind
	localparam int TOP_CMD = 7;
	localparam int TOP_DATA = 23;
	localparam int TOP_READ = 24;
	localparam int TOP_BYPASS = 0;
	localparam logic [IR_W-1:0] IR_ENABLE = 4'h6;
	localparam logic [IR_W-1:0] IR_BYPASS = 4'hF;
	localparam logic [1:0] STATUS_HALTED = 2'h3;
	localparam logic [1:0] STATUS_RUN = 2'h1;
	localparam logic [PTR_W-1:0] PTR_RESET = 4'h0;
	localparam logic [PTR_W-1:0] PTR_LAST = 4'hB;
	// timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int TCK_PERIOD_NS = 80;
	localparam int TCK_HALF_CYCLES = TCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam int ACK_PULSE_NS = 160;
	localparam int ACK_PULSE_CYCLES = (ACK_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESET_TMS_CYCLES = 5;
	// clk cycles the link-side reset request outlasts srst; sized for tck at clk/4 and the five-rise reset
	localparam int TCK_RST_HOLD_CYCLES = 8;

	typedef enum logic [CMD_SEL_W-1:0] {
		SEL_NONE, SEL_BUSWORD, SEL_LATCH, SEL_FETCH, SEL_DECODE, SEL_EXEC, SEL_TRACE, SEL_XBUF
	} dps_sel_t;
	typedef enum logic [3:0] {
		TAP_TLR, TAP_RTI, TAP_SELDR, TAP_CAPDR, TAP_SHDR, TAP_EX1DR, TAP_PAUSEDR, TAP_EX2DR,
		TAP_UPDDR, TAP_SELIR, TAP_CAPIR, TAP_SHIR, TAP_EX1IR, TAP_PAUSEIR, TAP_EX2IR, TAP_UPDIR
	} dps_tap_t;

	function automatic dps_sel_t dps_cmd_sel(input logic [CMD_W-1:0] cmd);
		return dps_sel_t'(cmd[CMD_SEL_LSB +: CMD_SEL_W]);
	endfunction
endpackage
`default_nettype wire

// ### core/dps_tap.sv
/*
 * Test access port state machine, stepped by the test clock.
 * Assumes rst and en are already synchronous to tck.
 */
`default_nettype none
module dps_tap (
	input wire logic tck,
	input wire logic rst,
	input wire logic en,
	input wire logic tms,
	output dps_pkg::dps_tap_t state
);
	import dps_pkg::*;
	dps_tap_t next_state;

	always_comb begin
		unique case (state)
			TAP_TLR: next_state = tms ? TAP_TLR : TAP_RTI;
			TAP_RTI: next_state = tms ? TAP_SELDR : TAP_RTI;
			TAP_SELDR: next_state = tms ? TAP_SELIR : TAP_CAPDR;
			TAP_CAPDR: next_state = tms ? TAP_EX1DR : TAP_SHDR;
			TAP_SHDR: next_state = tms ? TAP_EX1DR : TAP_SHDR;
			TAP_EX1DR: next_state = tms ? TAP_UPDDR : TAP_PAUSEDR;
			TAP_PAUSEDR: next_state = tms ? TAP_EX2DR : TAP_PAUSEDR;
			TAP_EX2DR: next_state = tms ? TAP_UPDDR : TAP_SHDR;
			TAP_UPDDR: next_state = tms ? TAP_SELDR : TAP_RTI;
			TAP_SELIR: next_state = tms ? TAP_TLR : TAP_CAPIR;
			TAP_CAPIR: next_state = tms ? TAP_EX1IR : TAP_SHIR;
			TAP_SHIR: next_state = tms ? TAP_EX1IR : TAP_SHIR;
			TAP_EX1IR: next_state = tms ? TAP_UPDIR : TAP_PAUSEIR;
			TAP_PAUSEIR: next_state = tms ? TAP_EX2IR : TAP_PAUSEIR;
			TAP_EX2IR: next_state = tms ? TAP_UPDIR : TAP_SHIR;
			TAP_UPDIR: next_state = tms ? TAP_SELDR : TAP_RTI;
		endcase
	end

	always_ff @(posedge tck) begin
		if (rst) begin
			state <= TAP_TLR;
		end else if (en) begin
			state <= next_state;
		end
	end
endmodule // dps_tap
`default_nettype wire

// ### dv/debug_port_sequencer_tb.sv
/*
 * Self-checking bench: host end and device end joined by the link.
 * Assumes the package, interface and both ends compile first.
 */
`default_nettype none
module debug_port_sequencer_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import dps_pkg::*;
	logic clk, srst, haltReq, instrDone, traceWe, traceInvalid, xbufWe;
	logic [WORD_W-1:0] fetchAddr, decodeAddr, execAddr, programDataBus, instrLatchIn, traceAddr, xbufData;
	logic halted, execStart, latchWrite, resume, scanStart, scanIr, scanBusy, scanDone, haltAckSeen;
	logic [WORD_W-1:0] execWord, instrLatchWord, programAddrBus;
	logic [LEN_W-1:0] scanLen;
	logic [SCAN_W-1:0] scanData, scanResult;
	logic [63:0] scanQ[$];
	logic [63:0] e;
	logic [25:0] coreQ[$];
	logic [25:0] obs;
	logic [24:0] traceExp[TRACE_DEPTH];
	logic [WORD_W-1:0] saved[6];
	int n_mismatch = 0;
	int samples_checked = 0;
	dps_if dps_if_i ();
	dps_device_end dps_device_end_i (.clk(clk), .srst(srst), .ce(1'h1), .link(dps_if_i), .haltReq(haltReq),
		.instrDone(instrDone), .fetchAddr(fetchAddr), .decodeAddr(decodeAddr), .execAddr(execAddr),
		.programDataBus(programDataBus), .instrLatchIn(instrLatchIn), .traceWe(traceWe), .traceAddr(traceAddr),
		.traceInvalid(traceInvalid), .xbufWe(xbufWe), .xbufData(xbufData), .halted(halted),
		.execStart(execStart), .execWord(execWord), .latchWrite(latchWrite), .instrLatchWord(instrLatchWord),
		.resume(resume), .programAddrBus(programAddrBus));
	dps_host_end dps_host_end_i (.clk(clk), .srst(srst), .ce(1'h1), .link(dps_if_i), .scanStart(scanStart),
		.scanIr(scanIr), .scanLen(scanLen), .scanData(scanData), .scanBusy(scanBusy), .scanDone(scanDone),
		.scanResult(scanResult), .haltAckSeen(haltAckSeen));
	dps_link_sva dps_link_sva_i (.clk(clk), .srst(srst), .tck(dps_if_i.tck), .tms(dps_if_i.tms),
		.tdi(dps_if_i.tdi), .tdo(dps_if_i.tdo), .haltAckN(dps_if_i.haltAckN));
	assign obs = execStart ? {2'h0, execWord} : (latchWrite ? {2'h1, instrLatchWord} : {2'h2, programAddrBus});

	task automatic tally(input logic ok, input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (ok !== 1'h1) begin
			n_mismatch++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_scan(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
		tally((got & mask) === exp, got, exp);
	endtask
	task automatic cmp_core(input logic [25:0] got, input logic [25:0] exp);
		tally(got === exp, {6'h00, got}, {6'h00, exp});
	endtask
	task automatic conclude;
		n_mismatch += coreQ.size() + scanQ.size();
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// one scan, issued and awaited at the falling edge
	task automatic scan(input logic ir, input int len, input logic [31:0] data, input logic [31:0] mask,
		input logic [31:0] exp);
		int n;
		n = 0;
		scanQ.push_back({mask, exp});
		scanIr = ir;
		scanLen = LEN_W'(len);
		scanData = data;
		scanStart = 1'h1;
		@(negedge clk);
		scanStart = 1'h0;
		cmp_core({25'h0, scanBusy}, 26'h1);
		while (scanDone !== 1'h1 && n < 1000) begin
			@(negedge clk);
			n++;
		end
		if (n == 1000) tally(1'h0, 32'(n), 32'h0);
		repeat (8) @(negedge clk);
	endtask
	task automatic cmd(input logic [7:0] c);
		scan(1'h0, CMD_W, {24'h0, c}, 32'hFF, 32'h0);
	endtask
	task automatic read(input int sel, input int len, input logic [31:0] exp);
		cmd(8'(8'h80 | sel));
		scan(1'h0, len, 32'h0, 32'((64'h1 << len) - 64'h1), exp);
	endtask
	task automatic write(input logic [7:0] c, input logic [WORD_W-1:0] d, input logic [25:0] exp);
		coreQ.push_back(exp);
		cmd(c);
		scan(1'h0, WORD_W, {8'h0, d}, 32'hFFFFFF, 32'h0);
	endtask
	task automatic wait_ack;
		int n;
		n = 0;
		while (haltAckSeen !== 1'h1 && n < 2000) begin
			@(negedge clk);
			n++;
		end
		cmp_core({25'h0, haltAckSeen}, 26'h1);
		repeat (8) @(negedge clk);
	endtask
	task automatic done_pulse;
		instrDone = 1'h1;
		@(negedge clk);
		instrDone = 1'h0;
		wait_ack();
	endtask

	always @(posedge clk) begin
		if (scanDone === 1'h1) begin
			e = scanQ.size() ? scanQ.pop_front() : {32'hFFFFFFFF, 32'hx};
			cmp_scan(scanResult, e[31:0], e[63:32]);
		end
		if ((execStart | latchWrite | resume) === 1'h1) cmp_core(obs, coreQ.size() ? coreQ.pop_front() : 26'h3FFFFFF);
	end
	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end
	initial begin
		#400000;
		n_mismatch++;
		conclude();
	end
	initial begin
		logic [WORD_W-1:0] op;
		logic [WORD_W-1:0] w;
		{srst, haltReq, instrDone, traceWe, traceInvalid, xbufWe, scanStart, scanIr} = 8'h80;
		{fetchAddr, decodeAddr, execAddr, programDataBus, instrLatchIn, traceAddr, xbufData} = '0;
		{scanLen, scanData} = '0;
		void'($urandom(76));
		repeat (6) @(negedge clk);
		srst = 1'h0;
		for (int i = 0; i < TRACE_DEPTH; i++) begin
			traceAddr = WORD_W'($urandom);
			traceInvalid = 1'($urandom);
			traceExp[i] = {traceAddr, traceInvalid};
			traceWe = 1'h1;
			@(negedge clk);
			traceWe = 1'h0;
		end
		w = WORD_W'($urandom);
		scan(1'h1, IR_W, 32'(IR_BYPASS), 32'hF, {30'h0, STATUS_RUN});
		scan(1'h0, CMD_W, {24'h0, w[7:0]}, 32'hFF, {24'h0, w[6:0], 1'h0});
		scan(1'h1, IR_W, 32'(IR_ENABLE), 32'hF, {30'h0, STATUS_RUN});
		for (int s = 1; s < 6; s++) saved[s] = WORD_W'($urandom);
		{programDataBus, instrLatchIn, fetchAddr, decodeAddr, execAddr} = {saved[1], saved[2], saved[3], saved[4], saved[5]};
		haltReq = 1'h1;
		wait_ack();
		haltReq = 1'h0;
		{programDataBus, instrLatchIn, fetchAddr, decodeAddr, execAddr} = ~{saved[1], saved[2], saved[3], saved[4], saved[5]};
		cmp_core({25'h0, halted}, 26'h1);
		scan(1'h1, IR_W, 32'(IR_ENABLE), 32'hF, {30'h0, STATUS_HALTED});
		for (int s = 1; s < 6; s++) read(s, WORD_W, {8'h0, saved[s]});
		for (int i = 0; i <= TRACE_DEPTH; i++) read(SEL_TRACE, TRACE_W, {7'h0, traceExp[i % TRACE_DEPTH]});
		xbufData = WORD_W'($urandom);
		xbufWe = 1'h1;
		@(negedge clk);
		xbufWe = 1'h0;
		read(SEL_XBUF, WORD_W, {8'h0, xbufData});
		op = WORD_W'($urandom);
		write(8'h41, op, {2'h0, op});
		cmp_core({25'h0, halted}, 26'h0);
		done_pulse();
		coreQ.push_back({2'h0, op});
		cmd(8'h40);
		done_pulse();
		w = WORD_W'($urandom);
		write(8'h01, w, {2'h1, w});
		read(SEL_BUSWORD, WORD_W, {8'h0, w});
		write(8'h61, WORD_W'($urandom), {2'h2, saved[3]});
		cmp_core({25'h0, halted}, 26'h0);
		scan(1'h1, IR_W, 32'(IR_ENABLE), 32'hF, {30'h0, STATUS_RUN});
		conclude();
	end
endmodule // debug_port_sequencer_tb
`default_nettype wire

// ### dv/dps_link_sva.sv
/*
 * Checker for the serial test link between host end and device end.
 * Assumes clk is the clock the host divides into tck and srst its reset.
 */
`default_nettype none
module dps_link_sva (
	input wire logic clk,
	input wire logic srst,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic tdo,
	input wire logic haltAckN
);
	timeunit 1ns;
	timeprecision 100ps;
	import dps_pkg::*;
	logic [4:0] ackLow;
	logic [4:0] next_ackLow;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	// length of the current low stretch of the halt acknowledge
	always_comb begin
		next_ackLow = haltAckN ? 5'h00 : ackLow + 5'h01;
	end
	always_ff @(posedge clk) begin
		ackLow <= srst ? 5'h00 : next_ackLow;
	end
	sequence s_ackLow;
		(!haltAckN) [*7];
	endsequence
	sequence s_tckHigh;
		tck ##1 !tck;
	endsequence
	property p_ack_pulse;
		$fell(haltAckN) |=> s_ackLow ##1 haltAckN;
	endproperty
	property p_ack_len;
		ackLow <= 5'h08;
	endproperty
	property p_tck_high;
		$rose(tck) |=> s_tckHigh;
	endproperty
	property p_tck_low;
		$fell(tck) |=> !tck;
	endproperty
	property p_tms_fall;
		$changed(tms) |-> $fell(tck);
	endproperty
	property p_tdi_fall;
		$changed(tdi) |-> $fell(tck);
	endproperty
	property p_tdo_rise;
		$changed(tdo) |-> $rose(tck);
	endproperty
	property p_hold;
		$rose(tck) |-> $stable(tdi) && $stable(tms);
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("halt ack pulse length wrong");
	a_ack_len: assert property (p_ack_len) else $error("halt ack low too long");
	a_tck_high: assert property (p_tck_high) else $error("tck high phase wrong");
	a_tck_low: assert property (p_tck_low) else $error("tck low phase too short");
	a_tms_fall: assert property (p_tms_fall) else $error("tms moved off a tck fall");
	a_tdi_fall: assert property (p_tdi_fall) else $error("tdi moved off a tck fall");
	a_tdo_rise: assert property (p_tdo_rise) else $error("tdo moved off a tck rise");
	a_hold: assert property (p_hold) else $error("tdi or tms moved at tck rise");
endmodule // dps_link_sva
`default_nettype wire
